// File: cim_pkg.sv
// Package: register map, field layout and reset values of the input matrix
package cim_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int CIM_N_CH = 4;
    localparam int CIM_N_DRV = 2;
    localparam int CIM_N_PIN = 3;
    localparam int CIM_ADDR_W = 8;
    localparam int CIM_DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CIM_OUT_LOW_OFS = 8'h00;
    localparam logic [7:0] CIM_OUT_HIGH_OFS = 8'h04;
    localparam logic [7:0] CIM_IN_CFG_OFS = 8'h08;
    localparam logic [7:0] CIM_HW_CFG_OFS = 8'h0c;
    localparam logic [7:0] CIM_DIAG_CFG_OFS = 8'h10;
    localparam logic [7:0] CIM_STATUS_OFS = 8'h14;
    localparam logic [7:0] CIM_ERROR_OFS = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CIM_DRV0_POS = 0;
    localparam int CIM_DRV1_POS = 1;
    localparam int CIM_COMPAT_POS = 2;
    localparam int CIM_MAP_POS = 0;
    localparam int CIM_COMB_POS = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] CIM_OUT_LOW_RST = 4'h0;
    localparam logic [2:0] CIM_OUT_HIGH_RST = 3'h0;
    localparam logic [1:0] CIM_IN_CFG_RST = 2'h0;
    localparam logic [1:0] CIM_HW_CFG_RST = 2'h0;
    localparam logic [2:0] CIM_DIAG_CFG_RST = 3'h0;

    // ----------------------------------------------------------------
    // Diagnosis select codes and bus responses
    // ----------------------------------------------------------------
    localparam logic [2:0] CIM_DIAG_SEL_A = 3'h4;
    localparam logic [2:0] CIM_DIAG_SEL_B = 3'h5;
    localparam logic [1:0] CIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] CIM_RESP_SLVERR = 2'h2;

endpackage

// File: cim_matrix_if.sv
// Interface: configuration into and requests out of the input matrix
`timescale 1ns/1ps
interface cim_matrix_if;
    logic map_sel;
    logic combine;
    logic [3:0] ch_bits;
    logic [1:0] drv_bits;
    logic [2:0] pins_sync;
    logic [3:0] ch_req;
    logic [1:0] drv_req;

    modport matrix (
        input map_sel, combine, ch_bits, drv_bits,
        output pins_sync, ch_req, drv_req
    );
    modport ctrl (
        output map_sel, combine, ch_bits, drv_bits,
        input pins_sync, ch_req, drv_req
    );
endinterface

// File: cim_input_matrix.sv
// Input synchroniser and pin-to-channel switch matrix
`timescale 1ns/1ps
module cim_input_matrix
    import cim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] in_pins,
    cim_matrix_if.matrix mx
);
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;
    logic [5:0] has_pin;
    logic [5:0] pin_val;
    logic [5:0] reg_bit;
    logic [5:0] req;

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    always_comb begin
        next_sync_a = in_pins;
        next_sync_b = sync_a;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    assign mx.pins_sync = sync_b;

    // ----------------------------------------------------------------
    // Pin selection per output
    // ----------------------------------------------------------------
    always_comb begin
        reg_bit = {mx.drv_bits, mx.ch_bits};
        if (mx.map_sel) begin
            has_pin = 6'h3f;
            pin_val = {sync_b[2], sync_b[2], sync_b[2], sync_b[2],
                       sync_b[1], sync_b[0]};
        end else begin
            has_pin = 6'h0e;
            pin_val = {2'h0, sync_b, 1'h0};
        end
    end

    // ----------------------------------------------------------------
    // Register bit and pin combination
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 6; i++) begin : g_comb
        always_comb begin
            if (!has_pin[i]) begin
                req[i] = reg_bit[i];
            end else if (mx.combine) begin
                req[i] = reg_bit[i] & pin_val[i];
            end else begin
                req[i] = reg_bit[i] | pin_val[i];
            end
        end
    end

    assign mx.ch_req = req[3:0];
    assign mx.drv_req = req[5:4];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_sync_delay;
        $past(rst_n, 2) |-> sync_b == $past(in_pins, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("pin synchroniser delay is not two cycles");
endmodule

// File: cim_top.sv
// Top: register slave, channel state and external driver control
`timescale 1ns/1ps
module cim_top
    import cim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic input_pin_a,
    input wire logic input_pin_b,
    input wire logic input_pin_c,
    input wire logic [3:0] inverse_current,
    input wire logic [3:0] over_temp,
    input wire logic [3:0] over_current,
    input wire logic logic_supply_ok,
    output logic [3:0] channel_on,
    output logic [1:0] lamp_led_mode,
    output logic [1:0] ext_drive_output,
    output logic ext_diag_output_first,
    output logic ext_diag_output_second
);
    import cim_pkg::*;

    cim_matrix_if mx ();

    logic [3:0] output_low_register;
    logic [2:0] output_high_register;
    logic [1:0] input_config_register;
    logic [1:0] hardware_config_register;
    logic [2:0] diag_config_register;
    logic [3:0] error_flags;
    logic [3:0] next_output_low_register;
    logic [2:0] next_output_high_register;
    logic [1:0] next_input_config_register;
    logic [1:0] next_hardware_config_register;
    logic [2:0] next_diag_config_register;
    logic [3:0] next_error_flags;
    logic next_awready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [3:0] next_channel_on;
    logic [1:0] next_ext_drive;
    logic next_diag_first;
    logic next_diag_second;
    logic wr_take;
    logic wr_en;
    logic rd_take;
    logic [7:0] wr_ofs;
    logic [7:0] rd_ofs;
    logic wr_hit;
    logic [3:0] err_clr;
    logic [3:0] err_set;
    logic [3:0] trip;
    logic [31:0] rd_word;
    logic rd_hit;
    logic diag_sel_a;
    logic diag_sel_b;

    // ----------------------------------------------------------------
    // Input matrix
    // ----------------------------------------------------------------
    assign mx.map_sel = input_config_register[CIM_MAP_POS];
    assign mx.combine = input_config_register[CIM_COMB_POS];
    assign mx.ch_bits = output_low_register;
    assign mx.drv_bits = {output_high_register[CIM_DRV1_POS],
                          output_high_register[CIM_DRV0_POS]};

    cim_input_matrix u_matrix (
        .clk(clk),
        .rst_n(rst_n),
        .in_pins({input_pin_c, input_pin_b, input_pin_a}),
        .mx(mx)
    );

    // ----------------------------------------------------------------
    // Bus write path
    // ----------------------------------------------------------------
    always_comb begin
        wr_take = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
        wr_ofs = {s_axi_awaddr[7:2], 2'h0};
        wr_hit = (wr_ofs == CIM_OUT_LOW_OFS) ||
                 (wr_ofs == CIM_OUT_HIGH_OFS) ||
                 (wr_ofs == CIM_IN_CFG_OFS) ||
                 (wr_ofs == CIM_HW_CFG_OFS) ||
                 (wr_ofs == CIM_DIAG_CFG_OFS) ||
                 (wr_ofs == CIM_STATUS_OFS) ||
                 (wr_ofs == CIM_ERROR_OFS);
        wr_en = wr_take & s_axi_wstrb[0];
        next_awready = s_axi_awvalid & s_axi_wvalid &
                       ~s_axi_awready & ~s_axi_bvalid;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (wr_take) begin
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? CIM_RESP_OKAY : CIM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_comb begin
        next_output_low_register = output_low_register;
        next_output_high_register = output_high_register;
        next_input_config_register = input_config_register;
        next_hardware_config_register = hardware_config_register;
        next_diag_config_register = diag_config_register;
        err_clr = 4'h0;
        if (wr_en) begin
            unique case (wr_ofs)
                CIM_OUT_LOW_OFS: begin
                    next_output_low_register = s_axi_wdata[3:0];
                end
                CIM_OUT_HIGH_OFS: begin
                    next_output_high_register = s_axi_wdata[2:0];
                end
                CIM_IN_CFG_OFS: begin
                    next_input_config_register = s_axi_wdata[1:0];
                end
                CIM_HW_CFG_OFS: begin
                    next_hardware_config_register = s_axi_wdata[1:0];
                end
                CIM_DIAG_CFG_OFS: begin
                    next_diag_config_register = s_axi_wdata[2:0];
                end
                CIM_ERROR_OFS: begin
                    err_clr = s_axi_wdata[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_low_register <= CIM_OUT_LOW_RST;
            output_high_register <= CIM_OUT_HIGH_RST;
            input_config_register <= CIM_IN_CFG_RST;
            hardware_config_register <= CIM_HW_CFG_RST;
            diag_config_register <= CIM_DIAG_CFG_RST;
        end else begin
            output_low_register <= next_output_low_register;
            output_high_register <= next_output_high_register;
            input_config_register <= next_input_config_register;
            hardware_config_register <= next_hardware_config_register;
            diag_config_register <= next_diag_config_register;
        end
    end

    // LED select drives timing, trip level and sense ratio of ch2/ch3
    assign lamp_led_mode = hardware_config_register;

    // ----------------------------------------------------------------
    // Bus read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_take = s_axi_arready & s_axi_arvalid;
        rd_ofs = {s_axi_araddr[7:2], 2'h0};
        rd_word = 32'h0;
        rd_hit = 1'b1;
        unique case (rd_ofs)
            CIM_OUT_LOW_OFS: rd_word[3:0] = output_low_register;
            CIM_OUT_HIGH_OFS: rd_word[2:0] = output_high_register;
            CIM_IN_CFG_OFS: rd_word[1:0] = input_config_register;
            CIM_HW_CFG_OFS: rd_word[1:0] = hardware_config_register;
            CIM_DIAG_CFG_OFS: rd_word[2:0] = diag_config_register;
            CIM_STATUS_OFS: rd_word[10:0] = {ext_diag_output_second,
                ext_diag_output_first, ext_drive_output,
                mx.pins_sync, channel_on};
            CIM_ERROR_OFS: rd_word[3:0] = error_flags;
            default: rd_hit = 1'b0;
        endcase
        next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_hit ? CIM_RESP_OKAY : CIM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CIM_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= CIM_RESP_OKAY;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // Channel state and error flags
    // ----------------------------------------------------------------
    always_comb begin
        trip = over_temp | over_current;
        err_set = trip & ~inverse_current;
        next_error_flags = (error_flags & ~err_clr) | err_set;
        for (int i = 0; i < CIM_N_CH; i++) begin
            if (inverse_current[i]) begin
                next_channel_on[i] = channel_on[i];
            end else begin
                // Pins act on channel_on the same in every supply mode
                next_channel_on[i] = mx.ch_req[i] & ~trip[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_on <= 4'h0;
            error_flags <= 4'h0;
        end else begin
            channel_on <= next_channel_on;
            error_flags <= next_error_flags;
        end
    end

    // ----------------------------------------------------------------
    // External driver control
    // ----------------------------------------------------------------
    always_comb begin
        diag_sel_a = diag_config_register == CIM_DIAG_SEL_A;
        diag_sel_b = diag_config_register == CIM_DIAG_SEL_B;
        next_ext_drive = 2'h0;
        next_diag_first = 1'b0;
        next_diag_second = 1'b0;
        if (logic_supply_ok) begin
            next_ext_drive = mx.drv_req;
            if (output_high_register[CIM_COMPAT_POS]) begin
                next_diag_first = diag_sel_a | diag_sel_b;
                next_diag_second = diag_sel_b;
            end else begin
                next_diag_first = diag_sel_a;
                next_diag_second = diag_sel_b;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_drive_output <= 2'h0;
            ext_diag_output_first <= 1'b0;
            ext_diag_output_second <= 1'b0;
        end else begin
            ext_drive_output <= next_ext_drive;
            ext_diag_output_first <= next_diag_first;
            ext_diag_output_second <= next_diag_second;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_or_mode;
        !mx.combine && output_low_register[1] && !inverse_current[1] &&
            !trip[1] |=> channel_on[1];
    endproperty
    a_or_mode: assert property (p_or_mode)
        else $error("OR mode channel 1 not on");

    property p_and_mode;
        mx.combine && !mx.map_sel && !mx.pins_sync[0] &&
            !inverse_current[1] |=> !channel_on[1];
    endproperty
    a_and_mode: assert property (p_and_mode)
        else $error("AND mode channel 1 on with pin low");

    property p_direct_pin;
        !mx.map_sel && !mx.combine && mx.pins_sync[2] &&
            !inverse_current[3] && !trip[3] |=> channel_on[3];
    endproperty
    a_direct_pin: assert property (p_direct_pin)
        else $error("direct pin c did not turn on channel 3");

    property p_direct_ch0;
        !mx.map_sel && !output_low_register[0] &&
            !inverse_current[0] |=> !channel_on[0];
    endproperty
    a_direct_ch0: assert property (p_direct_ch0)
        else $error("channel 0 on without its bit in direct mode");

    property p_assigned_drv;
        mx.map_sel && !mx.combine && mx.pins_sync[2] &&
            logic_supply_ok |=> ext_drive_output == 2'h3;
    endproperty
    a_assigned_drv: assert property (p_assigned_drv)
        else $error("pin c did not drive both external drivers");

    property p_inverse_hold;
        inverse_current[0] && !error_flags[0] |=>
            $stable(channel_on[0]) && !error_flags[0];
    endproperty
    a_inverse_hold: assert property (p_inverse_hold)
        else $error("inverse current changed state or set error");

    property p_no_supply;
        !logic_supply_ok |=> ext_drive_output == 2'h0 &&
            !ext_diag_output_first && !ext_diag_output_second;
    endproperty
    a_no_supply: assert property (p_no_supply)
        else $error("driver outputs active without logic supply");

    property p_compat_diag;
        output_high_register[CIM_COMPAT_POS] && logic_supply_ok &&
            diag_config_register == 3'h5 ##1 $stable(diag_config_register)
            |-> ext_diag_output_first && ext_diag_output_second;
    endproperty
    a_compat_diag: assert property (p_compat_diag)
        else $error("compat code 101 did not give enable and select");
endmodule

// File: cim_ext_drv_model.sv
// External smart driver model seen from the control outputs
`timescale 1ns/1ps
module cim_ext_drv_model (
    input wire logic [1:0] drive_in,
    input wire logic diag_en,
    input wire logic diag_sel,
    output logic [1:0] load_on,
    output logic [1:0] sense_src
);
    // Loads follow the control inputs
    assign load_on = drive_in;
    assign sense_src = diag_en ? {diag_sel, ~diag_sel} : 2'h0;
endmodule

// File: tb.sv
// Self-checking bench of the input matrix top
`timescale 1ns/1ps
module tb;
    import cim_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, sup = 1'h1, d0, d1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rd_val;
    logic [1:0] bresp, rresp, resp, led, drv, load;
    logic [2:0] pins = 3'h0;
    logic [3:0] inv = 4'h0, ot = 4'h0, oc = 4'h0, ch;
    int bad_count = 0, comparisons = 0, cycles = 0;
    cim_top cim_top_inst (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .input_pin_a(pins[0]), .input_pin_b(pins[1]),
        .input_pin_c(pins[2]), .inverse_current(inv), .over_temp(ot),
        .over_current(oc), .logic_supply_ok(sup), .channel_on(ch),
        .lamp_led_mode(led), .ext_drive_output(drv),
        .ext_diag_output_first(d0), .ext_diag_output_second(d1));
    cim_ext_drv_model cim_ext_drv_model_inst (.drive_in(drv), .diag_en(d0),
        .diag_sel(d1), .load_on(load), .sense_src());
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test;
        end
    end
    task finish_test;
        if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        comparisons++;
        if (seen !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd_val = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask
    task settle;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task t_reset;
        chk("ch", ch, 4'h0);
        chk("drv", {d1, d0, drv}, 4'h0);
        rd(CIM_IN_CFG_OFS);
        chk("in_cfg", rd_val, 32'h0);
        chk("rd resp", resp, CIM_RESP_OKAY);
        rd(8'h40);
        chk("unmapped resp", resp, CIM_RESP_SLVERR);
        chk("unmapped data", rd_val, 32'h0);
        wr(8'h40, 32'h0);
        chk("wr unmapped", resp, CIM_RESP_SLVERR);
    endtask
    task t_direct;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pins <= i[2:0];
            settle;
            chk("direct ch", ch, {i[2:0], 1'h0});
            chk("direct drv", drv, 2'h0);
        end
    endtask
    task t_regs;
        pins <= 3'h4;
        wr(CIM_OUT_LOW_OFS, 32'h1);
        chk("wr resp", resp, CIM_RESP_OKAY);
        settle;
        chk("reg ch", ch, 4'h9);
        wr(CIM_OUT_HIGH_OFS, 32'h3);
        settle;
        chk("drv on", drv, 2'h3);
        chk("load", load, 2'h3);
        rd(CIM_STATUS_OFS);
        chk("status", rd_val, 32'h1c9);
        sup <= 1'h0;
        settle;
        chk("drv nosup", drv, 2'h0);
        sup <= 1'h1;
        wr(CIM_OUT_HIGH_OFS, 32'h0);
        wr(CIM_OUT_LOW_OFS, 32'h0);
    endtask
    task t_and;
        wr(CIM_IN_CFG_OFS, 32'h2);
        wr(CIM_OUT_LOW_OFS, 32'h6);
        pins <= 3'h0;
        settle;
        chk("and low", ch, 4'h0);
        pins <= 3'h1;
        settle;
        chk("and a", ch, 4'h2);
        pins <= 3'h3;
        settle;
        chk("and ab", ch, 4'h6);
    endtask
    task t_assign;
        wr(CIM_OUT_LOW_OFS, 32'h0);
        wr(CIM_IN_CFG_OFS, 32'h1);
        rd(CIM_IN_CFG_OFS);
        chk("map bit", rd_val, 32'h1);
        for (int i = 0; i < 3; i++) begin
            pins <= 3'h1 << i;
            settle;
            chk("asg ch", ch, (i == 2) ? 4'hc : 4'h1 << i);
            chk("asg drv", drv, (i == 2) ? 2'h3 : 2'h0);
        end
        pins <= 3'h0;
        wr(CIM_IN_CFG_OFS, 32'h0);
    endtask
    task t_inv;
        wr(CIM_OUT_LOW_OFS, 32'h3);
        inv <= 4'h1;
        oc <= 4'h1;
        wr(CIM_OUT_LOW_OFS, 32'h2);
        settle;
        chk("inv hold", ch, 4'h3);
        rd(CIM_ERROR_OFS);
        chk("inv err", rd_val, 32'h0);
        inv <= 4'h0;
        oc <= 4'h0;
        ot <= 4'h2;
        settle;
        chk("trip", ch, 4'h0);
        rd(CIM_ERROR_OFS);
        chk("err set", rd_val, 32'h2);
        ot <= 4'h0;
        wr(CIM_ERROR_OFS, 32'h2);
        rd(CIM_ERROR_OFS);
        chk("err clr", rd_val, 32'h0);
    endtask
    task t_diag;
        wr(CIM_HW_CFG_OFS, 32'h2);
        settle;
        chk("led", led, 2'h2);
        for (int i = 0; i < 4; i++) begin
            wr(CIM_OUT_HIGH_OFS, i[1] ? 32'h4 : 32'h0);
            wr(CIM_DIAG_CFG_OFS, i[0] ? 32'h5 : 32'h4);
            settle;
            chk("diag", {d1, d0}, {i[0], ~i[0] | i[1]});
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        t_reset;
        t_direct;
        t_regs;
        t_and;
        t_assign;
        t_inv;
        t_diag;
        finish_test;
    end
endmodule
